//--- hw/fgi_port.sv
`timescale 1ns/1ps
`include "fgi_consts.svh"
// Summary of operation
// - quick read returns the byte at the current address pointer.
// - pointer advances by one whenever a data byte is acknowledged by anyone.
// - incremental write uses the same incrementing pointer for consecutive locations.
// - data written to a read-only location is answered with NACK.
// - command byte above the last location is answered with NACK.
// - written read-write values may appear on read-back only after a delay.
// - in low-power modes stretch briefly on every transfer while waking.
// - in normal mode stretch only on packets addressed to this target.
// - stretch may follow start, ack bits and first read data bit.
// - flow-control stretches last as long as loc_ready is low, with no FLOW_CYC limit.
// - stretch during table update may last up to the long bound.
// - answer the fixed seven-bit target address with direction bit.
// - support single, incremental, quick reads and single, incremental writes.
module fgi_port
    import fgi_pkg::*;
#(
    parameter int FLOW_CYC = `FGI_FLOW_CYC,
    parameter int NVM_CYC = `FGI_NVM_CYC
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    // bus pins
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // mode inputs
    input wire logic low_power,
    input wire logic nvm_busy,
    // command location access
    output logic [7:0] loc_addr,
    input wire logic [7:0] loc_rdata,
    input wire logic loc_ro,
    output logic loc_we,
    output logic [7:0] loc_wdata,
    input wire logic loc_ready
);
    import fgi_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            {scl_m, scl_s, scl_d, sda_m, sda_s, sda_d} <= 6'h3f;
        end
        else if (clk_en)
        begin
            scl_m <= scl_in;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= sda_in;
            sda_s <= sda_m;
            sda_d <= sda_s;
        end
    end

    logic scl_rise, scl_fall, start_c, stop_c;
    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign start_c = scl_s && scl_d && sda_d && !sda_s;
    assign stop_c = scl_s && scl_d && !sda_d && sda_s;

    // ------------------------------------------------------------
    // byte engine
    // ------------------------------------------------------------
    fgi_state_t state;
    fgi_state_t after_ack;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic [7:0] ptr;
    logic ack_drive, rd_bit, mine, hold, first_rd;
    logic [31:0] wait_cnt;

    // holding scl only while engine or storage is not ready
    logic busy_stretch;
    assign busy_stretch = hold && (!loc_ready || wait_cnt != 32'h0);
    assign scl_out = 1'b0;
    assign scl_oe = busy_stretch && !scl_s;
    assign sda_out = 1'b0;
    assign sda_oe = ack_drive || (state == FGI_RDAT && !rd_bit);
    assign loc_addr = ptr;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state <= FGI_IDLE;
            after_ack <= FGI_IDLE;
            shift <= 8'h00;
            bit_cnt <= 4'h0;
            ptr <= 8'h00;
            ack_drive <= 1'b0;
            rd_bit <= 1'b1;
            mine <= 1'b0;
            hold <= 1'b0;
            first_rd <= 1'b0;
            wait_cnt <= 32'h0;
            loc_we <= 1'b0;
            loc_wdata <= 8'h00;
        end
        else if (clk_en)
        begin
            loc_we <= 1'b0;
            if (wait_cnt != 32'h0)
            begin
                wait_cnt <= wait_cnt - 32'h1;
            end
            if (hold && !busy_stretch)
            begin
                hold <= 1'b0;
            end
            if (stop_c)
            begin
                state <= FGI_IDLE;
                ack_drive <= 1'b0;
                rd_bit <= 1'b1;
                mine <= 1'b0;
                hold <= 1'b0;
            end
            else if (start_c)
            begin
                state <= FGI_ADDR;
                bit_cnt <= 4'h0;
                ack_drive <= 1'b0;
                rd_bit <= 1'b1;
                if (low_power)
                begin
                    // wake stretch for every packet, addressed or not
                    hold <= 1'b1;
                    wait_cnt <= 32'(`FGI_WAKE_CYC);
                end
            end
            else
            begin
                case (state)
                    FGI_IDLE:
                    begin
                    end
                    FGI_ADDR, FGI_CMD, FGI_WDAT:
                    begin
                        if (scl_rise)
                        begin
                            shift <= {shift[6:0], sda_s};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        if (scl_fall && bit_cnt == 4'h8)
                        begin
                            bit_cnt <= 4'h0;
                            state <= FGI_ACK;
                            hold <= 1'b1;
                            wait_cnt <= nvm_busy ? 32'(NVM_CYC) : 32'h0;
                            if (state == FGI_ADDR)
                            begin
                                mine <= shift[7:1] == `FGI_TARGET_ADDR;
                                ack_drive <= shift[7:1] == `FGI_TARGET_ADDR;
                                // normal mode: foreign packets never stretched
                                if (shift[7:1] != `FGI_TARGET_ADDR && !low_power)
                                begin
                                    hold <= 1'b0;
                                end
                                after_ack <= shift[7:1] != `FGI_TARGET_ADDR ? FGI_IDLE :
                                    (shift[0] ? FGI_RDAT : FGI_CMD);
                                first_rd <= shift[0];
                            end
                            else if (state == FGI_CMD)
                            begin
                                ack_drive <= shift <= `FGI_CMD_LAST;
                                ptr <= shift;
                                after_ack <= shift <= `FGI_CMD_LAST ? FGI_WDAT : FGI_IDLE;
                            end
                            else
                            begin
                                ack_drive <= !loc_ro;
                                loc_we <= !loc_ro;
                                // the store decides when read-back shows the new value
                                loc_wdata <= shift;
                                ptr <= loc_ro ? ptr : ptr + 8'h01;
                                after_ack <= loc_ro ? FGI_IDLE : FGI_WDAT;
                            end
                        end
                    end
                    FGI_ACK:
                    begin
                        if (scl_fall)
                        begin
                            ack_drive <= 1'b0;
                            state <= after_ack;
                            if (!mine)
                            begin
                                state <= FGI_IDLE;
                            end
                            if (after_ack == FGI_RDAT)
                            begin
                                shift <= {loc_rdata[6:0], 1'b0};
                                rd_bit <= loc_rdata[7];
                                bit_cnt <= 4'h1;
                            end
                        end
                    end
                    FGI_RDAT:
                    begin
                        if (scl_fall)
                        begin
                            if (bit_cnt == 4'h1 && first_rd)
                            begin
                                // stretch after first read bit while data settles
                                hold <= 1'b1;
                                first_rd <= 1'b0;
                            end
                            if (bit_cnt == 4'h8)
                            begin
                                rd_bit <= 1'b1;
                                bit_cnt <= 4'h0;
                                state <= FGI_RACK;
                            end
                            else
                            begin
                                rd_bit <= shift[7];
                                shift <= {shift[6:0], 1'b0};
                                bit_cnt <= bit_cnt + 4'h1;
                            end
                        end
                    end
                    FGI_RACK:
                    begin
                        if (scl_rise)
                        begin
                            if (!sda_s)
                            begin
                                ptr <= ptr + 8'h01;
                                after_ack <= FGI_RDAT;
                            end
                            else
                            begin
                                after_ack <= FGI_IDLE;
                            end
                        end
                        if (scl_fall)
                        begin
                            state <= after_ack;
                            if (after_ack == FGI_RDAT)
                            begin
                                shift <= {loc_rdata[6:0], 1'b0};
                                rd_bit <= loc_rdata[7];
                                bit_cnt <= 4'h1;
                            end
                        end
                    end
                    default:
                    begin
                        state <= FGI_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

//--- hw/fgi_consts.svh
`ifndef FGI_CONSTS_SVH
`define FGI_CONSTS_SVH
`define FGI_TARGET_ADDR 7'h55
`define FGI_CMD_LAST 8'h6b
`define FGI_CLK_MHZ 200
`define FGI_WAKE_US 75
`define FGI_WAKE_CYC ((`FGI_WAKE_US * `FGI_CLK_MHZ) - 1)
`define FGI_FLOW_MS 4
`define FGI_FLOW_CYC (`FGI_FLOW_MS * 1000 * `FGI_CLK_MHZ)
`define FGI_NVM_MS 144
`define FGI_NVM_CYC (`FGI_NVM_MS * 1000 * `FGI_CLK_MHZ)
`endif

//--- hw/fgi_pkg.sv
package fgi_pkg;
    typedef enum logic [6:0] {
        FGI_IDLE = 7'h01,
        FGI_ADDR = 7'h02,
        FGI_CMD = 7'h04,
        FGI_WDAT = 7'h08,
        FGI_RDAT = 7'h10,
        FGI_ACK = 7'h20,
        FGI_RACK = 7'h40
    } fgi_state_t;
endpackage

//--- sim/fgi_port_sva.sv
`timescale 1ns/1ps
module fgi_port_chk
#(
    parameter int FLOW_CYC = 800000,
    parameter int NVM_CYC = 200
)
(
    // watched ports
    input wire logic core_clk,
    input wire logic rst,
    input wire logic low_power,
    input wire logic nvm_busy,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic [7:0] loc_addr,
    input wire logic loc_ro,
    input wire logic loc_we
);
    localparam int WAKE_CYC = 15000;
    int scl_cnt;
    // length of the stretch in progress
    always_ff @(posedge core_clk)
    begin
        if (rst || !scl_oe)
            scl_cnt <= 0;
        else
            scl_cnt <= scl_cnt + 1;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_pins_pull_low: assert property (!scl_out && !sda_out) else $error("pin driven high");
    chk_reset_idle: assert property ($fell(rst) |-> !scl_oe && !sda_oe && !loc_we && loc_addr == 8'h00)
        else $error("not idle after reset");
    chk_write_step: assert property (loc_we |-> loc_addr == $past(loc_addr) + 8'h01)
        else $error("pointer not stepped");
    chk_write_pulse: assert property (loc_we |=> !loc_we) else $error("write pulse too long");
    chk_ro_no_write: assert property (loc_we |-> !$past(loc_ro)) else $error("read-only written");
    chk_data_steady: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("sda moved while scl high");
    chk_flow_bound: assert property (!low_power && !nvm_busy |-> scl_cnt <= FLOW_CYC)
        else $error("flow stretch too long");
    chk_stretch_max: assert property (scl_cnt <= NVM_CYC + WAKE_CYC) else $error("stretch too long");
endmodule

//--- sim/fgi_host.sv
`timescale 1ns/1ps
module fgi_host (
    // pull-down requests
    output logic scl_dn = 1'b0,
    output logic sda_dn = 1'b0,
    // wire levels
    input wire logic scl,
    input wire logic sda
);
    // no control subcommand, block_checksum_command or full standard-command sweep is ever sent,
    // so the read-back waits and the sweep rate limit never fall due
    // release scl and sit out any stretch, bounded so a hang cannot stall us
    task automatic rise();
        int n;
        n = 0;
        scl_dn = 1'b0;
        while (scl !== 1'b1 && n < 40000)
            #4 n++;
        #32;
    endtask
    // one bit out in the low phase, wire level back at the end of high
    task automatic bit_io(input logic b, output logic r);
        #16 sda_dn = !b;
        #16 rise();
        r = sda;
        scl_dn = 1'b1;
    endtask
    // start, also usable as repeated start
    task automatic start();
        #16 sda_dn = 1'b0;
        #16 rise();
        sda_dn = 1'b1;
        #32 scl_dn = 1'b1;
    endtask
    // stop, then a bus-free gap
    task automatic stop();
        #16 sda_dn = 1'b1;
        #16 rise();
        sda_dn = 1'b0;
        #200;
    endtask
    // msb first, then the acknowledge slot
    task automatic xbyte(input logic [7:0] tx, input logic hack, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(tx[i], rx[i]);
        bit_io(hack, ack);
    endtask
endmodule

//--- sim/tb_fgi_port.sv
`timescale 1ns/1ps
module tb_fgi_port;
    localparam int NVM_SIM = 200;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic low_power = 1'b0;
    logic nvm_busy = 1'b0;
    logic clk_en = 1'b1;
    logic loc_ready = 1'b1;
    logic scl_oe, sda_oe, loc_we, scl_dn, sda_dn, ack;
    logic [7:0] loc_addr, loc_wdata, prev_addr, rx;
    logic [7:0] mem [256];
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    int str = 0;
    int max_str = 0;
    wire scl = !(scl_dn || scl_oe);
    wire sda = !(sda_dn || sda_oe);
    always #2.5 core_clk = !core_clk;
    fgi_host host (.scl_dn(scl_dn), .sda_dn(sda_dn), .scl(scl), .sda(sda));
    fgi_port #(.NVM_CYC(NVM_SIM)) dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .scl_in(scl), .scl_out(),
        .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .low_power(low_power), .nvm_busy(nvm_busy),
        .loc_addr(loc_addr), .loc_rdata(mem[loc_addr]), .loc_ro(loc_addr < 8'h08), .loc_we(loc_we),
        .loc_wdata(loc_wdata), .loc_ready(loc_ready));
    // location store (pointer has already moved at the pulse), stretch meter, run limit
    always @(posedge core_clk)
    begin
        prev_addr <= loc_addr;
        if (loc_we)
            mem[prev_addr] <= loc_wdata;
        str <= scl_oe ? str + 1 : 0;
        if (str > max_str)
            max_str <= str;
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            error_cnt++;
            summarize();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic [7:0] b, input logic nack);
        host.xbyte(b, 1'b1, rx, ack);
        check({7'h00, ack}, {7'h00, nack});
    endtask
    task automatic rb(input logic hack, input logic [7:0] exp);
        host.xbyte(8'hff, hack, rx, ack);
        check(rx, exp);
    endtask
    // two data bytes into consecutive locations
    task automatic t_write();
        host.start();
        wb(8'haa, 1'b0);
        wb(8'h20, 1'b0);
        wb(8'h12, 1'b0);
        wb(8'h34, 1'b0);
        host.stop();
        check(mem[8'h20], 8'h12);
        check(mem[8'h21], 8'h34);
    endtask
    // incremental read, then quick read where the pointer stopped
    task automatic t_read();
        host.start();
        wb(8'haa, 1'b0);
        wb(8'h20, 1'b0);
        host.start();
        wb(8'hab, 1'b0);
        rb(1'b0, 8'h12);
        rb(1'b1, 8'h34);
        host.stop();
        host.start();
        wb(8'hab, 1'b0);
        rb(1'b1, 8'h34);
        host.stop();
    endtask
    // last location, one past it, read-only target, foreign address
    task automatic t_refuse();
        host.start();
        wb(8'haa, 1'b0);
        wb(8'h6c, 1'b1);
        host.stop();
        host.start();
        wb(8'haa, 1'b0);
        wb(8'h6b, 1'b0);
        host.stop();
        host.start();
        wb(8'haa, 1'b0);
        wb(8'h03, 1'b0);
        wb(8'h77, 1'b1);
        host.stop();
        check(mem[8'h03], 8'h59);
        host.start();
        wb(8'ha8, 1'b1);
        host.stop();
    endtask
    // longest stretch over one address byte in a given mode
    task automatic t_stretch(input logic lp, input logic nb, input logic [7:0] a, input int lo, input int hi);
        @(negedge core_clk);
        low_power = lp;
        nvm_busy = nb;
        max_str = 0;
        host.start();
        host.xbyte(a, 1'b1, rx, ack);
        host.stop();
        check({7'h00, max_str >= lo && max_str <= hi}, 8'h01);
        @(negedge core_clk);
        low_power = 1'b0;
        nvm_busy = 1'b0;
    endtask
    // clock held until storage is ready, or for a table update with the clock enable dropped meanwhile
    task automatic t_hold(input logic nb, input int lo, input int hi);
        @(negedge core_clk);
        nvm_busy = nb;
        loc_ready = nb;
        max_str = 0;
        fork
            begin
                host.start();
                host.xbyte(8'haa, 1'b1, rx, ack);
                host.stop();
            end
            begin
                wait (scl_oe === 1'b1);
                @(negedge core_clk);
                clk_en = !nb;
                repeat (50) @(negedge core_clk);
                loc_ready = 1'b1;
                clk_en = 1'b1;
            end
        join
        check({7'h00, max_str >= lo && max_str <= hi}, 8'h01);
        @(negedge core_clk);
        nvm_busy = 1'b0;
    endtask
    task automatic summarize();
        if (error_cnt == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i) ^ 8'h5a;
        repeat (4) @(negedge core_clk);
        rst = 1'b0;
        repeat (4) @(negedge core_clk);
        t_write();
        t_read();
        t_refuse();
        t_stretch(1'b0, 1'b0, 8'ha8, 0, 0);
        t_stretch(1'b1, 1'b0, 8'ha8, 14900, 15100);
        t_stretch(1'b0, 1'b1, 8'haa, NVM_SIM / 2, NVM_SIM + 16);
        t_hold(1'b0, 48, 52);
        t_hold(1'b1, NVM_SIM + 48, NVM_SIM + 52);
        summarize();
    end
endmodule
bind fgi_port fgi_port_chk #(.FLOW_CYC(FLOW_CYC), .NVM_CYC(NVM_CYC)) chk (.core_clk(core_clk), .rst(rst),
    .low_power(low_power), .nvm_busy(nvm_busy), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_out(sda_out), .sda_oe(sda_oe), .loc_addr(loc_addr), .loc_ro(loc_ro), .loc_we(loc_we));
